// ### src/can_ext_id_pkg.sv
// Package: constants and carrier types for the extended identifier buffer block
package can_ext_id_pkg;

    // APB geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte addresses (one aligned word each)
    localparam logic [ADDR_W-1:0] OFS_TX_TOP = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TX_UMID = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TX_LMID = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_TX_LOW = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_RX_TOP = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RX_UMID = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_RX_LMID = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_RX_LOW = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;

    // Identifier byte fields (upper-mid byte)
    localparam int SRR_POS = 4;
    localparam int IDE_POS = 3;
    // Remote request flag position in the low byte
    localparam int RTR_POS = 0;

    // Arbitration field lengths in bits on the bus
    localparam logic [5:0] EXT_FRAME_BITS = 6'h20;
    localparam logic [5:0] STD_FRAME_BITS = 6'h0D;
    localparam int WORD_BITS = 32;

    // Control and status bit positions
    localparam int CTRL_START_POS = 0;
    localparam int ST_BUSY_POS = 0;
    localparam int ST_DONE_POS = 1;
    localparam int ST_LOST_POS = 2;
    localparam int ST_RXFULL_POS = 3;

    // Reset values
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [5:0] CNT_RESET = 6'h00;

    typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
    typedef enum logic {RX_IDLE, RX_COLLECT} rx_state_t;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    // Bit-level link from the protocol engine (same clock)
    typedef struct packed {
        logic tx_tick;
        logic bus_bit;
        logic rx_start;
        logic rx_tick;
        logic rx_bit;
    } link_in_t;

    // Whole block state
    typedef struct packed {
        logic [31:0] tx_word;
        logic [31:0] rx_word;
        logic [31:0] tx_shift;
        logic [5:0] tx_cnt;
        logic [5:0] tx_len;
        tx_state_t tx_state;
        logic [31:0] rx_shift;
        logic [5:0] rx_cnt;
        rx_state_t rx_state;
        logic tx_done;
        logic arb_lost;
        logic rx_full;
        apb_rsp_t rsp;
        logic tx_bit;
        logic tx_active;
    } state_t;

endpackage

// ### src/can_ext_id_buf.sv
// Identifier bytes of one transmit and one receive buffer, with APB access
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module can_ext_id_buf
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // APB slave
    input wire can_ext_id_pkg::apb_req_t i_apb,
    output logic [can_ext_id_pkg::DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Protocol engine link
    input wire can_ext_id_pkg::link_in_t i_link,
    output logic o_tx_bit,
    output logic o_tx_active
);
    import can_ext_id_pkg::*;

    state_t q;
    state_t d;

    // Buffer word layout, bus order from bit 31 down:
    //   31..24 ID 28..21
    //   23..21 ID 20..18, 20 SRR, 19 format flag, 18..16 ID 17..15
    //   15..8 ID 14..7
    //   7..1 ID 6..0, 0 remote flag
    // A standard frame uses only bits 31..19: ID 10..0, remote flag, format flag.
    // One word in bus order lets the serialiser shift it out unchanged,
    // at the cost of a shifter in every byte access.
    // Software bytes map onto it through get_byte and put_byte only.

    // Byte i of a buffer word; byte 0 is the top identifier byte
    function automatic logic [7:0] get_byte(input logic [31:0] w, input logic [1:0] idx);
        logic [4:0] sh;
        sh = 5'(WORD_BITS - 8) - {idx, 3'b000};
        get_byte = 8'(w >> sh);
    endfunction

    // Replace byte i of a buffer word
    function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] idx,
                                             input logic [7:0] b);
        logic [4:0] sh;
        sh = 5'(WORD_BITS - 8) - {idx, 3'b000};
        put_byte = (w & ~(32'h0000_00FF << sh)) | (32'({b}) << sh);
    endfunction

    // Number of bus bits for a buffer, chosen by its format flag
    function automatic logic [5:0] frame_len(input logic [31:0] w);
        frame_len = w[WORD_BITS - 16 + IDE_POS] ? EXT_FRAME_BITS : STD_FRAME_BITS;
    endfunction

    logic access;
    logic wr_edge;
    logic [DATA_W-1:0] rd_val;
    logic rd_err;
    logic [31:0] rx_next;
    logic [5:0] rx_cnt_next;
    logic tx_busy;
    logic tx_wr;
    logic start_req;
    logic st_wr;
    logic tx_lost;
    logic tx_last;
    logic rx_std_end;
    logic rx_ext_end;

    // APB phase qualifiers; one wait state, write lands on the pready edge
    assign access = i_apb.psel && i_apb.penable;
    assign wr_edge = access && q.rsp.pready && i_apb.pwrite;

    // Read decode
    always_comb
    begin
        rd_val = '0;
        rd_err = 1'b0;
        unique case (i_apb.paddr)
            OFS_TX_TOP:
            begin
                rd_val = 32'(get_byte(q.tx_word, 2'd0));
            end
            OFS_TX_UMID:
            begin
                rd_val = 32'(get_byte(q.tx_word, 2'd1));
            end
            OFS_TX_LMID:
            begin
                rd_val = 32'(get_byte(q.tx_word, 2'd2));
            end
            OFS_TX_LOW:
            begin
                rd_val = 32'(get_byte(q.tx_word, 2'd3));
            end
            OFS_RX_TOP:
            begin
                rd_val = 32'(get_byte(q.rx_word, 2'd0));
            end
            OFS_RX_UMID:
            begin
                rd_val = 32'(get_byte(q.rx_word, 2'd1));
            end
            OFS_RX_LMID:
            begin
                rd_val = 32'(get_byte(q.rx_word, 2'd2));
            end
            OFS_RX_LOW:
            begin
                rd_val = 32'(get_byte(q.rx_word, 2'd3));
            end
            OFS_CTRL:
            begin
                rd_val = '0;
            end
            OFS_STATUS:
            begin
                rd_val[ST_BUSY_POS] = tx_busy;
                rd_val[ST_DONE_POS] = q.tx_done;
                rd_val[ST_LOST_POS] = q.arb_lost;
                rd_val[ST_RXFULL_POS] = q.rx_full;
            end
            default:
            begin
                rd_err = 1'b1;
            end
        endcase
    end

    // Receive shifter look-ahead, MSB first as it arrives
    assign rx_next = {q.rx_shift[30:0], i_link.rx_bit};
    assign rx_cnt_next = q.rx_cnt + 6'd1;

    // Busy while a frame is on the bus; buffer writes and new starts are dropped until idle
    assign tx_busy = (q.tx_state == TX_SEND);
    assign tx_wr = wr_edge && !tx_busy;
    assign start_req = tx_wr && (i_apb.paddr == OFS_CTRL) && i_apb.pwdata[CTRL_START_POS];
    assign st_wr = wr_edge && (i_apb.paddr == OFS_STATUS);

    // Transmit events, looked at only on a bit tick
    assign tx_lost = q.tx_bit && !i_link.bus_bit;
    assign tx_last = (q.tx_cnt + 6'd1) == q.tx_len;

    // Receive frame ends; the format flag is the 13th bit in both formats
    assign rx_std_end = (rx_cnt_next == STD_FRAME_BITS) && !i_link.rx_bit;
    assign rx_ext_end = rx_cnt_next == EXT_FRAME_BITS;

    // Next-state logic
    always_comb
    begin
        d = q;

        // APB answer: raise pready after the first access cycle, drop it one cycle later
        d.rsp.pready = 1'b0;
        d.rsp.pslverr = 1'b0;
        if (access && !q.rsp.pready)
        begin
            d.rsp.pready = 1'b1;
            d.rsp.pslverr = rd_err;
            d.rsp.prdata = i_apb.pwrite ? '0 : rd_val;
        end

        // Transmit buffer writes; locked while a frame is on the bus
        if (tx_wr)
        begin
            unique case (i_apb.paddr)
                OFS_TX_TOP:
                begin
                    d.tx_word = put_byte(q.tx_word, 2'd0, i_apb.pwdata[7:0]);
                end
                OFS_TX_UMID:
                begin
                    d.tx_word = put_byte(q.tx_word, 2'd1, i_apb.pwdata[7:0]);
                end
                OFS_TX_LMID:
                begin
                    d.tx_word = put_byte(q.tx_word, 2'd2, i_apb.pwdata[7:0]);
                end
                OFS_TX_LOW:
                begin
                    d.tx_word = put_byte(q.tx_word, 2'd3, i_apb.pwdata[7:0]);
                end
                default:
                begin
                end
            endcase
        end

        // Status write-one-to-clear; hardware sets below win
        if (st_wr)
        begin
            if (i_apb.pwdata[ST_DONE_POS])
            begin
                d.tx_done = 1'b0;
            end
            if (i_apb.pwdata[ST_LOST_POS])
            begin
                d.arb_lost = 1'b0;
            end
            if (i_apb.pwdata[ST_RXFULL_POS])
            begin
                d.rx_full = 1'b0;
            end
        end

        // Transmit serialiser; byte order of the word is the bus order
        unique case (q.tx_state)
            TX_IDLE:
            begin
                d.tx_active = 1'b0;
                d.tx_bit = 1'b1;
                if (start_req)
                begin
                    d.tx_state = TX_SEND;
                    d.tx_shift = q.tx_word;
                    d.tx_len = frame_len(q.tx_word);
                    d.tx_cnt = CNT_RESET;
                    d.tx_bit = q.tx_word[WORD_BITS-1];
                    d.tx_active = 1'b1;
                end
            end
            TX_SEND:
            begin
                if (i_link.tx_tick)
                begin
                    // Recessive sent but dominant seen: a smaller identifier wins
                    if (tx_lost)
                    begin
                        d.tx_state = TX_IDLE;
                        d.arb_lost = 1'b1;
                        d.tx_active = 1'b0;
                        d.tx_bit = 1'b1;
                    end
                    else if (tx_last)
                    begin
                        d.tx_state = TX_IDLE;
                        d.tx_done = 1'b1;
                        d.tx_active = 1'b0;
                        d.tx_bit = 1'b1;
                    end
                    else
                    begin
                        d.tx_shift = {q.tx_shift[30:0], 1'b1};
                        d.tx_bit = q.tx_shift[WORD_BITS-2];
                        d.tx_cnt = q.tx_cnt + 6'd1;
                    end
                end
            end
        endcase

        // Receive deserialiser; a new start always restarts collection
        if (i_link.rx_start)
        begin
            d.rx_state = RX_COLLECT;
            d.rx_cnt = CNT_RESET;
            d.rx_shift = WORD_RESET;
        end
        else
        begin
            unique case (q.rx_state)
                RX_IDLE:
                begin
                end
                RX_COLLECT:
                begin
                    if (i_link.rx_tick)
                    begin
                        d.rx_shift = rx_next;
                        d.rx_cnt = rx_cnt_next;
                        // Format flag is the 13th bit in both formats
                        if (rx_std_end)
                        begin
                            // Standard frame: left-aligned, unused low bits zero
                            d.rx_word = {rx_next[12:0], 19'h0_0000};
                            d.rx_full = 1'b1;
                            d.rx_state = RX_IDLE;
                        end
                        else if (rx_ext_end)
                        begin
                            // SRR stored exactly as sampled
                            d.rx_word = rx_next;
                            d.rx_full = 1'b1;
                            d.rx_state = RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // State register
    // Buffers clear to zero so a read before any frame gives a defined value;
    // the pointless reset cost is small next to an unknown on the bus interface
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            q.tx_word <= WORD_RESET;
            q.rx_word <= WORD_RESET;
            q.tx_shift <= WORD_RESET;
            q.tx_cnt <= CNT_RESET;
            q.tx_len <= CNT_RESET;
            q.tx_state <= TX_IDLE;
            q.rx_shift <= WORD_RESET;
            q.rx_cnt <= CNT_RESET;
            q.rx_state <= RX_IDLE;
            q.tx_done <= 1'b0;
            q.arb_lost <= 1'b0;
            q.rx_full <= 1'b0;
            q.rsp <= '0;
            q.tx_bit <= 1'b1; // Recessive idle level
            q.tx_active <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from state flops
    assign o_prdata = q.rsp.prdata;
    assign o_pready = q.rsp.pready;
    assign o_pslverr = q.rsp.pslverr;
    assign o_tx_bit = q.tx_bit;
    assign o_tx_active = q.tx_active;

endmodule // can_ext_id_buf

`default_nettype wire

// ### verif/can_ext_id_chk.sv
// Checker: bus answer and link timing of the identifier buffer block
`timescale 1ns/1ps
`default_nettype none
module can_ext_id_chk
(
    // Watched ports
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire can_ext_id_pkg::apb_req_t i_apb,
    input wire logic [can_ext_id_pkg::DATA_W-1:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire can_ext_id_pkg::link_in_t i_link,
    input wire logic o_tx_bit,
    input wire logic o_tx_active
);
    import can_ext_id_pkg::*;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    // APB answers: one wait state, one cycle wide
    AST_WAIT: assert property (i_apb.psel && i_apb.penable && !o_pready |=> o_pready)
        else $error("pready late");
    AST_RDY_ONE: assert property (o_pready |=> !o_pready)
        else $error("pready too long");
    AST_NO_REQ: assert property (!(i_apb.psel && i_apb.penable) |=> !o_pready)
        else $error("pready without access");
    AST_ERR_RDY: assert property (o_pslverr |-> o_pready)
        else $error("pslverr alone");
    AST_WR_ZERO: assert property (o_pready && i_apb.pwrite |-> o_prdata == 32'h0000_0000)
        else $error("prdata on write");
    // Start write launches the frame next cycle
    AST_START: assert property (o_pready && i_apb.pwrite && i_apb.paddr == OFS_CTRL &&
        i_apb.pwdata[0] && !o_tx_active |=> o_tx_active)
        else $error("start not taken");
    // A bit stands until its tick; idle line is recessive
    AST_HOLD: assert property (o_tx_active && !i_link.tx_tick |=> o_tx_active && $stable(o_tx_bit))
        else $error("bit moved without tick");
    AST_IDLE: assert property (!o_tx_active |-> o_tx_bit)
        else $error("idle not recessive");
    // Recessive sent, dominant seen: back off at once
    AST_LOST: assert property (o_tx_active && i_link.tx_tick && o_tx_bit && !i_link.bus_bit
        |=> !o_tx_active)
        else $error("arbitration loss ignored");
endmodule // can_ext_id_chk
bind can_ext_id_buf can_ext_id_chk u_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_apb(i_apb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_link(i_link), .o_tx_bit(o_tx_bit), .o_tx_active(o_tx_active));
`default_nettype wire

// ### verif/can_bus_model.sv
// Bus-side model: bit ticks, wired-AND bus level and a receive bit stream
`timescale 1ns/1ps
`default_nettype none
module can_bus_model
(
    // Clock, reset and design pins
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_tx_bit,
    input wire logic i_tx_active,
    // Scenario controls
    input wire logic [31:0] i_rival,
    input wire logic [1:0] i_gap,
    input wire logic i_rx_go,
    input wire logic [31:0] i_rx_word,
    input wire logic [5:0] i_rx_len,
    // Link to the design
    output var can_ext_id_pkg::link_in_t o_link
);
    import can_ext_id_pkg::*;
    logic tick_q, start_q, rtick_q, rbit_q;
    logic [1:0] wait_q;
    logic [5:0] tidx_q, ridx_q;
    logic [31:0] rsh_q, rival_sh;
    // Dominant wins: the bus is the AND of both senders
    assign rival_sh = i_rival << tidx_q;
    assign o_link = '{tx_tick: tick_q, bus_bit: i_tx_bit & rival_sh[31], rx_start: start_q,
        rx_tick: rtick_q, rx_bit: rbit_q};
    // Ticks every gap+1 cycles; rx bits MSB first, line toggles between ticks
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            {tick_q, start_q, rtick_q, rbit_q, wait_q, tidx_q, ridx_q, rsh_q} <= '0;
        else
        begin
            tick_q <= i_tx_active && (wait_q == i_gap);
            wait_q <= (!i_tx_active || wait_q == i_gap) ? 2'h0 : wait_q + 2'h1;
            tidx_q <= !i_tx_active ? 6'h00 : tidx_q + {5'h00, tick_q};
            start_q <= i_rx_go;
            rtick_q <= !i_rx_go && (ridx_q != 6'h00);
            rbit_q <= (!i_rx_go && ridx_q != 6'h00) ? rsh_q[31] : ~rbit_q;
            rsh_q <= i_rx_go ? i_rx_word : rsh_q << 1;
            ridx_q <= i_rx_go ? i_rx_len : (ridx_q != 6'h00 ? ridx_q - 6'h01 : ridx_q);
        end
    end
endmodule // can_bus_model
`default_nettype wire

// ### verif/can_ext_id_mapping_tb.sv
// Testbench: register layout, transmit order, arbitration and receive capture
`timescale 1ns/1ps
`default_nettype none
module can_ext_id_mapping_tb;
    import can_ext_id_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    apb_req_t apb_q = '0;
    link_in_t link;
    logic [31:0] prdata;
    logic pready, pslverr, tx_bit, tx_active;
    logic [31:0] rival = 32'hFFFF_FFFF;
    logic [1:0] gap = 2'h0;
    logic rx_go = 1'b0;
    logic [31:0] rx_word = 32'h0000_0000;
    logic [5:0] rx_len = 6'h00;
    logic [31:0] cap = 32'h0000_0000;
    logic [5:0] ncap = 6'h00;
    logic act_q = 1'b0;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    // Clock
    always #5 i_core_clk = ~i_core_clk;
    can_ext_id_buf u_can_ext_id_buf (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_apb(apb_q),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_link(link),
        .o_tx_bit(tx_bit), .o_tx_active(tx_active));
    can_bus_model u_can_bus_model (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_tx_bit(tx_bit),
        .i_tx_active(tx_active), .i_rival(rival), .i_gap(gap), .i_rx_go(rx_go),
        .i_rx_word(rx_word), .i_rx_len(rx_len), .o_link(link));
    // Bits on the wire at each tick, restarted per frame; hang guard
    always @(posedge i_core_clk)
    begin
        act_q <= tx_active;
        cyc <= cyc + 1;
        if (tx_active && !act_q)
            {cap, ncap} <= '0;
        else if (tx_active && link.tx_tick)
            {cap, ncap} <= {cap[30:0], tx_bit, ncap + 6'h01};
        if (cyc == 5000)
        begin
            fails++;
            results();
        end
    end
    task automatic results;
        if (fails == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x)
        begin
            fails++;
            $display("BAD %s exp %h got %h", nm, x, g);
        end
    endtask
    // One APB transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge i_core_clk);
        apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge i_core_clk);
        apb_q.penable <= 1'b1;
        do
        begin
            @(posedge i_core_clk);
            n++;
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        apb_q.psel <= 1'b0;
        apb_q.penable <= 1'b0;
        chk("waits", 32'd2, 32'(n));
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(nm, x, r);
    endtask
    task automatic load(input logic [28:0] id, input logic srr, input logic rtr);
        wr(OFS_TX_TOP, {24'h00_0000, id[28:21]});
        wr(OFS_TX_UMID, {24'h00_0000, id[20:18], srr, 1'b1, id[17:15]});
        wr(OFS_TX_LMID, {24'h00_0000, id[14:7]});
        wr(OFS_TX_LOW, {24'h00_0000, id[6:0], rtr});
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        @(posedge i_core_clk);
        while (tx_active !== 1'b0 && n < 400)
        begin
            @(posedge i_core_clk);
            n++;
        end
        chk("idle", 32'h0, {31'h0, tx_active});
    endtask
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 10; i++)
            rd(8'(4 * i), 32'h0000_0000, "reset");
        chk("txbit", 32'h1, {31'h0, tx_bit});
        for (int i = 0; i < 4; i++)
            wr(8'(4 * i), {24'hFF_FFFF, 8'(8'hA5 - i)});
        for (int i = 0; i < 4; i++)
            rd(8'(4 * i), {24'h00_0000, 8'(8'hA5 - i)}, "rw");
        wr(OFS_RX_LMID, 32'h0000_00FF);
        rd(OFS_RX_LMID, 32'h0000_0000, "rxro");
        apb(1'b0, 8'h28, 32'h0000_0000, r, e);
        chk("unmapped", 32'h1, {31'h0, e});
        apb(1'b1, 8'h02, 32'h0000_0000, r, e);
        chk("unaligned", 32'h1, {31'h0, e});
    endtask
    task automatic t_tx(input logic [28:0] id, input logic rtr, input logic [1:0] g);
        gap <= g;
        load(id, 1'b1, rtr);
        wr(OFS_CTRL, 32'h0000_0001);
        rd(OFS_STATUS, 32'h0000_0001, "busy");
        wr(OFS_TX_TOP, 32'h0000_00FF);
        rd(OFS_TX_TOP, {24'h00_0000, id[28:21]}, "busywr");
        wait_idle();
        chk("frame", {id[28:18], 1'b1, 1'b1, id[17:0], rtr}, cap);
        chk("nbits", 32'd32, {26'h0, ncap});
        rd(OFS_STATUS, 32'h0000_0002, "done");
        wr(OFS_STATUS, 32'h0000_000E);
        rd(OFS_STATUS, 32'h0000_0000, "clear");
    endtask
    task automatic t_std(input logic [10:0] s);
        wr(OFS_TX_TOP, {24'h00_0000, s[10:3]});
        wr(OFS_TX_UMID, {24'h00_0000, s[2:0], 1'b1, 1'b0, 3'h0});
        wr(OFS_CTRL, 32'h0000_0001);
        wait_idle();
        chk("stdframe", {19'h0, s, 1'b1, 1'b0}, {19'h0, cap[12:0]});
        chk("stdbits", 32'd13, {26'h0, ncap});
        rd(OFS_STATUS, 32'h0000_0002, "stddone");
        wr(OFS_STATUS, 32'h0000_000E);
    endtask
    task automatic t_arb;
        rival <= 32'h0018_0000;
        load(29'h0010_0000, 1'b1, 1'b0);
        wr(OFS_CTRL, 32'h0000_0001);
        wait_idle();
        chk("lostat", 32'd9, {26'h0, ncap});
        rd(OFS_STATUS, 32'h0000_0004, "lost");
        wr(OFS_STATUS, 32'h0000_000E);
        rival <= 32'hFFFF_FFFF;
    endtask
    task automatic rx(input logic [31:0] w, input logic [5:0] len);
        rx_word <= w;
        rx_len <= len;
        rx_go <= 1'b1;
        @(posedge i_core_clk);
        rx_go <= 1'b0;
        repeat (40) @(posedge i_core_clk);
    endtask
    task automatic t_rx;
        logic [28:0] id;
        logic [10:0] s;
        id = 29'h1234_5678;
        s = 11'h3C5;
        rx({id[28:18], 1'b0, 1'b1, id[17:0], 1'b1}, 6'd32);
        rd(OFS_RX_TOP, {24'h00_0000, id[28:21]}, "rxtop");
        rd(OFS_RX_UMID, {24'h00_0000, id[20:18], 1'b0, 1'b1, id[17:15]}, "rxumid");
        rd(OFS_RX_LMID, {24'h00_0000, id[14:7]}, "rxlmid");
        rd(OFS_RX_LOW, {24'h00_0000, id[6:0], 1'b1}, "rxlow");
        rd(OFS_STATUS, 32'h0000_0008, "rxfull");
        rx({s, 1'b0, 1'b0, 19'h0}, 6'd13);
        rd(OFS_RX_TOP, {24'h00_0000, s[10:3]}, "stdtop");
        rd(OFS_RX_UMID, {24'h00_0000, s[2:0], 5'h00}, "stdumid");
        rd(OFS_RX_LOW, 32'h0000_0000, "stdlow");
        wr(OFS_STATUS, 32'h0000_0008);
        rd(OFS_STATUS, 32'h0000_0000, "rxclr");
    endtask
    // Main sequence
    initial
    begin
        repeat (5) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        t_regs();
        t_tx(29'h0ABC_1234, 1'b1, 2'h0);
        t_tx(29'h1555_AAAA, 1'b0, 2'h2);
        t_std(11'h5A3);
        t_arb();
        t_rx();
        results();
    end
endmodule // can_ext_id_mapping_tb
`default_nettype wire
